// >>> shared/jtap_pkg.sv
// Purpose: Constants and types shared by the test access port design.
// Assumes: Instruction codes other than the private range are house choices.
// Notes: Identification value is arbitrary.
package jtap_pkg;
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_VAL = 4'h1;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_PRIV_LO = 4'h8;
  localparam logic [3:0] OP_PRIV_HI = 4'hb;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam int ID_WIDTH = 32;
  // Arbitrary identification value, names no real part.
  localparam logic [31:0] ID_VALUE = 32'h1234_5001;
  localparam int BSC_WIDTH = 8;
  localparam int DBG_WIDTH = 16;
  localparam int TLR_TMS_COUNT = 5;
  typedef enum logic [3:0] {
    JTAP_TLR, JTAP_RTI, JTAP_SEL_DR, JTAP_CAP_DR, JTAP_SH_DR, JTAP_EX1_DR,
    JTAP_PAU_DR, JTAP_EX2_DR, JTAP_UPD_DR, JTAP_SEL_IR, JTAP_CAP_IR,
    JTAP_SH_IR, JTAP_EX1_IR, JTAP_PAU_IR, JTAP_EX2_IR, JTAP_UPD_IR
  } jtap_state_t;
endpackage

// >>> hdl/jtap_controller.sv
// Purpose: Test access port: state machine, instruction and data registers.
// Assumes: core_clk is much faster than the test clock; all pins are
//   synchronised with two flip-flops and test clock edges are detected.
// Notes: No bus registers; fuse and disable bit are plain inputs.
//   Limitation: each test clock phase must span four core clocks or more.
`timescale 1ns/1ps
`default_nettype none
module jtap_controller
  import jtap_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  input wire logic debug_enable_fuse,
  input wire logic [BSC_WIDTH-1:0] boundaryIn,
  input wire logic [DBG_WIDTH-1:0] debugIn,
  output logic tdoOut,
  output logic tdoOe,
  output logic pinPullupEn,
  output logic portAsTestPins,
  output logic [IR_WIDTH-1:0] instrOut,
  output logic [BSC_WIDTH-1:0] boundaryOut,
  output logic [DBG_WIDTH-1:0] debugOut,
  output logic runIdleActive
);
  // ==========================================================
  // Pin synchronisers
  // Every pin passes two flops; only the second stage is read.
  // Reset levels match the idle pins, clock low and the others pulled high,
  // so that no false test clock edge follows the release of reset.
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic tckLast_reg;
  logic portOn_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_reg <= 3'h3;
      pinSync_reg <= 3'h3;
      tckLast_reg <= 1'b0;
      portOn_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {tckPin, tmsPin, tdiPin};
      pinSync_reg <= pinMeta_reg;
      tckLast_reg <= pinSync_reg[2];
      portOn_reg <= test_port_enable_fuse && !test_port_disable_bit;
    end
  end
  // The fuse and disable bit come from this clock domain, so one register
  // stage is enough to line them up with the synchronised pins.
  logic tckRise;
  logic tckFall;
  logic tmsS;
  logic tdiS;
  assign tckRise = pinSync_reg[2] && !tckLast_reg;
  assign tckFall = !pinSync_reg[2] && tckLast_reg;
  // Disabled port forces TMS and TDI high, which also walks the machine home.
  assign tmsS = pinSync_reg[1] || !portOn_reg;
  assign tdiS = pinSync_reg[0] || !portOn_reg;

  // ==========================================================
  // TAP state machine
  // No test-reset pin: only reset_n (power-on), an unprogrammed enable fuse, or TMS high.
  jtap_state_t state_reg;
  jtap_state_t state_next;
  // Next state from the sampled mode select; the default arm sends any
  // stray code back to reset rather than leaving the port stuck.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JTAP_TLR: state_next = tmsS ? JTAP_TLR : JTAP_RTI;
      JTAP_RTI: state_next = tmsS ? JTAP_SEL_DR : JTAP_RTI;
      JTAP_SEL_DR: state_next = tmsS ? JTAP_SEL_IR : JTAP_CAP_DR;
      JTAP_CAP_DR: state_next = tmsS ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_SH_DR: state_next = tmsS ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_EX1_DR: state_next = tmsS ? JTAP_UPD_DR : JTAP_PAU_DR;
      JTAP_PAU_DR: state_next = tmsS ? JTAP_EX2_DR : JTAP_PAU_DR;
      JTAP_EX2_DR: state_next = tmsS ? JTAP_UPD_DR : JTAP_SH_DR;
      JTAP_UPD_DR: state_next = tmsS ? JTAP_SEL_DR : JTAP_RTI;
      // Five TMS-high edges reach TLR from any state by this graph.
      JTAP_SEL_IR: state_next = tmsS ? JTAP_TLR : JTAP_CAP_IR;
      JTAP_CAP_IR: state_next = tmsS ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_SH_IR: state_next = tmsS ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_EX1_IR: state_next = tmsS ? JTAP_UPD_IR : JTAP_PAU_IR;
      JTAP_PAU_IR: state_next = tmsS ? JTAP_EX2_IR : JTAP_PAU_IR;
      JTAP_EX2_IR: state_next = tmsS ? JTAP_UPD_IR : JTAP_SH_IR;
      JTAP_UPD_IR: state_next = tmsS ? JTAP_SEL_DR : JTAP_RTI;
      default: state_next = JTAP_TLR;
    endcase
  end

  // The state steps on each detected rising test clock edge.
  // An unprogrammed fuse overrides every edge and parks the machine.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= JTAP_TLR;
    end else if (!test_port_enable_fuse) begin
      state_reg <= JTAP_TLR;
    end else if (tckRise) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Instruction register
  // The shift stage is reloaded only on capture, so a pause keeps its bits;
  // the parallel copy is what the data registers decode.
  logic [IR_WIDTH-1:0] irShift_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irShift_reg <= IR_CAPTURE;
      instrOut <= IR_RESET_VAL;
    end else if (state_reg == JTAP_TLR) begin
      instrOut <= IR_RESET_VAL;
    end else if (tckRise) begin
      case (state_reg)
        JTAP_CAP_IR: irShift_reg <= IR_CAPTURE;
        // TDI enters at the top so the first bit ends as the LSB.
        JTAP_SH_IR: irShift_reg <= {tdiS, irShift_reg[IR_WIDTH-1:1]};
        JTAP_UPD_IR: instrOut <= irShift_reg;
        default: irShift_reg <= irShift_reg;
      endcase
    end
  end

  // ==========================================================
  // Data registers
  // Private range opens the debug chain only with the debug fuse set.
  logic selDebug;
  logic selId;
  logic selBsc;
  assign selDebug = instrOut >= OP_PRIV_LO && instrOut <= OP_PRIV_HI
    && debug_enable_fuse;
  assign selId = instrOut == OP_IDCODE;
  assign selBsc = instrOut == OP_EXTEST || instrOut == OP_SAMPLE;

  logic bypass_reg;
  logic [ID_WIDTH-1:0] idShift_reg;
  logic [BSC_WIDTH-1:0] bscShift_reg;
  logic [DBG_WIDTH-1:0] dbgShift_reg;
  // Capture and shift strobes, one core clock wide each.
  logic drCapture;
  logic drShift;
  logic selBypass;
  assign drCapture = tckRise && state_reg == JTAP_CAP_DR;
  assign drShift = tckRise && state_reg == JTAP_SH_DR;
  // Unlisted opcodes, and private ones without the fuse, fall to bypass so
  // that the chain length seen by the host stays defined.
  assign selBypass = !selDebug && !selId && !selBsc;

  // Bypass stage: cleared on capture, then a one-cycle delay of TDI.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_reg <= 1'b0;
    end else if (drCapture) begin
      bypass_reg <= 1'b0;
    end else if (drShift && selBypass) begin
      bypass_reg <= tdiS;
    end
  end

  // Identification register: a fixed word loaded on every capture.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idShift_reg <= '0;
    end else if (drCapture) begin
      idShift_reg <= ID_VALUE;
    end else if (drShift && selId) begin
      idShift_reg <= {tdiS, idShift_reg[ID_WIDTH-1:1]};
    end
  end

  // Boundary chain: samples the pin-side inputs on capture.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bscShift_reg <= '0;
    end else if (drCapture) begin
      bscShift_reg <= boundaryIn;
    end else if (drShift && selBsc) begin
      bscShift_reg <= {tdiS, bscShift_reg[BSC_WIDTH-1:1]};
    end
  end

  // Debug chain: samples the debug inputs on capture.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dbgShift_reg <= '0;
    end else if (drCapture) begin
      dbgShift_reg <= debugIn;
    end else if (drShift && selDebug) begin
      dbgShift_reg <= {tdiS, dbgShift_reg[DBG_WIDTH-1:1]};
    end
  end

  // Held parallel outputs move only in Update-DR.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boundaryOut <= '0;
      debugOut <= '0;
    end else if (tckRise && state_reg == JTAP_UPD_DR) begin
      if (selBsc) begin
        boundaryOut <= bscShift_reg;
      end
      if (selDebug) begin
        debugOut <= dbgShift_reg;
      end
    end
  end

  // ==========================================================
  // Scan output
  // The instruction path wins in Shift-IR; otherwise the selected data
  // register feeds TDO, with bypass covering every other opcode.
  logic scanBit;
  always_comb begin
    if (state_reg == JTAP_SH_IR) begin
      scanBit = irShift_reg[0];
    end else if (selDebug) begin
      scanBit = dbgShift_reg[0];
    end else if (selId) begin
      scanBit = idShift_reg[0];
    end else if (selBsc) begin
      scanBit = bscShift_reg[0];
    end else begin
      scanBit = bypass_reg;
    end
  end

  // TDO and, while the port is on, its enable move on the falling edge, giving the host half a
  // test clock of setup for its rising-edge sample.
  // A released TDO needs a board pull-up; the enable says when we drive.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tdoOut <= 1'b1;
      tdoOe <= 1'b0;
    end else if (!portOn_reg) begin
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdoOut <= scanBit;
      tdoOe <= state_reg == JTAP_SH_IR || state_reg == JTAP_SH_DR;
    end
  end

  // ==========================================================
  // Port status
  // Both pin flags follow the registered enable one clock later, so they
  // agree with the forced pin levels that the machine sees.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinPullupEn <= 1'b0;
    end else begin
      pinPullupEn <= portOn_reg;
    end
  end

  // Pins serve the test port only while it is enabled.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portAsTestPins <= 1'b0;
    end else begin
      portAsTestPins <= portOn_reg;
    end
  end

  // Run-Test/Idle is flagged busy while a private instruction holds with the debug fuse set; the
  // host must not treat that state as quiet then.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      runIdleActive <= 1'b0;
    end else begin
      runIdleActive <= state_reg == JTAP_RTI && selDebug;
    end
  end
endmodule
`default_nettype wire

// >>> verif/jtap_controller_assertions.sv
// Purpose: Port-level checks for the test access port.
// Assumes: TCK high and low phases each last at least four core clocks.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module jtap_controller_assertions
  import jtap_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tckPin,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  input wire logic debug_enable_fuse,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic pinPullupEn,
  input wire logic portAsTestPins,
  input wire logic [IR_WIDTH-1:0] instrOut,
  input wire logic [BSC_WIDTH-1:0] boundaryOut,
  input wire logic [DBG_WIDTH-1:0] debugOut,
  input wire logic runIdleActive
);
  // ==========================================
  // Checks
  // One clock domain, so clocking and reset masking are given once.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_pull;
    (test_port_enable_fuse && !test_port_disable_bit) [*4] |-> pinPullupEn;
  endproperty
  property p_off;
    !test_port_enable_fuse [*3] |-> !portAsTestPins && !pinPullupEn;
  endproperty
  property p_dis;
    test_port_disable_bit [*8] |-> !tdoOe;
  endproperty
  property p_tdo_edge;
    $changed(tdoOut) |-> !tckPin;
  endproperty
  property p_oe_rise;
    $rose(tdoOe) |-> !tckPin && portAsTestPins;
  endproperty
  // A fuse drop reloads the instruction with no test clock edge.
  property p_instr;
    $changed(instrOut) |-> tckPin || instrOut == IR_RESET_VAL;
  endproperty
  property p_bnd;
    $changed(boundaryOut) |->
      tckPin && (instrOut == OP_EXTEST || instrOut == OP_SAMPLE);
  endproperty
  property p_dbg;
    $changed(debugOut) |->
      tckPin && debug_enable_fuse && instrOut[3:2] == 2'b10;
  endproperty
  property p_idle;
    runIdleActive |-> $past(instrOut[3:2]) == 2'b10;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable low");
  a_off: assert property (p_off) else $error("port not released");
  a_dis: assert property (p_dis) else $error("TDO driven while off");
  a_tdo_edge: assert property (p_tdo_edge) else $error("TDO moved");
  a_oe_rise: assert property (p_oe_rise) else $error("TDO enable");
  a_instr: assert property (p_instr) else $error("instr moved");
  a_bnd: assert property (p_bnd) else $error("boundary moved");
  a_dbg: assert property (p_dbg) else $error("debug moved");
  a_idle: assert property (p_idle) else $error("idle activity");
  c_idle: cover property (runIdleActive);
  c_oe: cover property ($rose(tdoOe));
  c_dbg: cover property ($changed(debugOut));
endmodule
`default_nettype wire

// >>> verif/jtap_host_model.sv
// Purpose: Behavioural external test controller driving the port.
// Assumes: One TCK period spans eight core clocks.
// Notes: Released TDO reads as the board pull-up level.
`timescale 1ns/1ps
`default_nettype none
module jtap_host_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tdoOut,
  input wire logic tdoOe,
  output logic tckPin,
  output logic tmsPin,
  output logic tdiPin
);
  // ==========================================
  // Pins
  logic tdoLine;
  assign tdoLine = tdoOe ? tdoOut : 1'b1;
  // Idle levels match the internal pull-ups.
  initial begin
    tckPin = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
  end
  // One TCK period; TMS and TDI are held across the rise, and TDO is
  // read late in the high phase, long after its falling-edge update.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    // The debugger watches the reset line and stops clocking while it is low.
    while (!reset_n) @(posedge core_clk);
    @(posedge core_clk);
    tckPin <= 1'b0;
    tmsPin <= tms;
    tdiPin <= tdi;
    repeat (4) @(posedge core_clk);
    tckPin <= 1'b1;
    repeat (3) @(posedge core_clk);
    tdo = tdoLine;
  endtask
  // From Run-Test/Idle: select, shift LSB first, update, back to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    // Registered outputs follow the last rising edge one core clock later.
    repeat (2) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the test access port.
// Assumes: Host model paces TCK well below the core clock.
// Notes: Random data from a fixed seed; opcodes come from a table.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
  import jtap_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic test_port_enable_fuse = 1'b1;
  logic test_port_disable_bit = 1'b0;
  logic debug_enable_fuse = 1'b1;
  logic [BSC_WIDTH-1:0] boundaryIn = '0;
  logic [DBG_WIDTH-1:0] debugIn = '0;
  logic tckPin, tmsPin, tdiPin, tdoOut, tdoOe, pinPullupEn, b;
  logic portAsTestPins, runIdleActive;
  logic [IR_WIDTH-1:0] instrOut;
  logic [BSC_WIDTH-1:0] boundaryOut, lastBnd = '0;
  logic [DBG_WIDTH-1:0] debugOut, lastDbg = '0;
  logic [31:0] rd, wd, mask;
  logic [3:0] ops [9] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf, 4'h8};
  int err_total = 0;
  int num_checks = 0;
  int n;
  jtap_controller jtap_controller_i (.*);
  jtap_host_model jtap_host_model_i (.*);
  always #12.5 core_clk = ~core_clk;
  // ==========================================
  // Expectations
  function automatic int len_of(logic [3:0] op);
    if (op == OP_IDCODE) return ID_WIDTH;
    if (op == OP_EXTEST || op == OP_SAMPLE) return BSC_WIDTH;
    if (op[3:2] == 2'b10 && debug_enable_fuse) return DBG_WIDTH;
    return 5;
  endfunction
  // Bypass captures zero and delays TDI by one clock.
  function automatic logic [31:0] cap_of(logic [3:0] op, logic [31:0] d);
    if (op == OP_IDCODE) return ID_VALUE;
    if (len_of(op) == BSC_WIDTH) return 32'(boundaryIn);
    if (len_of(op) == DBG_WIDTH) return 32'(debugIn);
    return {d[30:0], 1'b0};
  endfunction
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected few thousand cycles.
  initial begin
    #(25 * 40000);
    err_total++;
    complete_run();
  end
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'hd6b8));
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(instrOut, IR_RESET_VAL)
    `CHK(pinPullupEn, 1'b1)
    jtap_host_model_i.tick(1'b0, 1'b0, b);
    `CHK(tdoOe, 1'b0)
    for (int k = 0; k < 9; k++) begin
      debug_enable_fuse <= (k != 8);
      boundaryIn <= BSC_WIDTH'($urandom);
      debugIn <= DBG_WIDTH'($urandom);
      wd = $urandom;
      jtap_host_model_i.scan(1'b1, IR_WIDTH, 32'(ops[k]), rd);
      `CHK(rd[3:0], IR_CAPTURE)
      `CHK(instrOut, ops[k])
      n = len_of(ops[k]);
      mask = (32'h1 << n) - 32'h1;
      jtap_host_model_i.scan(1'b0, n, wd, rd);
      `CHK(rd & mask, cap_of(ops[k], wd) & mask)
      if (n == BSC_WIDTH) lastBnd = wd[7:0];
      if (n == DBG_WIDTH) lastDbg = wd[15:0];
      `CHK(boundaryOut, lastBnd)
      `CHK(debugOut, lastDbg)
      `CHK(runIdleActive, n == DBG_WIDTH)
    end
    test_port_disable_bit <= 1'b1;
    jtap_host_model_i.scan(1'b1, IR_WIDTH, 32'h2, rd);
    `CHK(instrOut, OP_IDCODE)
    `CHK(pinPullupEn, 1'b0)
    test_port_disable_bit <= 1'b0;
    test_port_enable_fuse <= 1'b0;
    jtap_host_model_i.scan(1'b1, IR_WIDTH, 32'h2, rd);
    `CHK(portAsTestPins, 1'b0)
    `CHK(instrOut, OP_IDCODE)
    test_port_enable_fuse <= 1'b1;
    jtap_host_model_i.tick(1'b0, 1'b0, b);
    jtap_host_model_i.scan(1'b1, IR_WIDTH, 32'h2, rd);
    `CHK(instrOut, OP_SAMPLE)
    jtap_host_model_i.tick(1'b1, 1'b0, b);
    repeat (3) jtap_host_model_i.tick(1'b0, 1'b1, b);
    repeat (5) jtap_host_model_i.tick(1'b1, 1'b1, b);
    // The reset instruction reaches its register one clock after the state.
    repeat (2) @(posedge core_clk);
    `CHK(instrOut, IR_RESET_VAL)
    `CHK(tdoOe, 1'b0)
    complete_run();
  end
endmodule
bind jtap_controller jtap_controller_assertions jtap_controller_assertions_i (.*);
`default_nettype wire
